// >>> etb_pkg.sv
// Constants, types and encodings for the emulator trace, break and map core.
// Assumes one 40 MHz system clock shared with the emulated core's cycle logic.
package etb_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int TRACE_DEPTH = 255;
	localparam int TRACE_W = 44;
	localparam int BP_NUM = 3;
	localparam int BP_W = 15;
	localparam int PC_W = 12;
	localparam int MAP_BLOCKS = 16;
	localparam int BLOCK_BYTES = 256;
	localparam int MAP_W = MAP_BLOCKS + 1;
	localparam int DMA_AW = 16;
	localparam int DMA_DW = 48;
	localparam int CNT_W = 16;
	localparam int SNAP_W = 32;

	// ****************************************
	// Core clock synthesis
	// ****************************************
	localparam longint SYS_HZ = 40_000_000;
	localparam longint FAST_HZ = 6_000_000;
	localparam longint SLOW_HZ = 3_000_000;
	localparam int PH_W = 16;
	// Phase step per sys_clk; one carry is one half period
	localparam logic [PH_W-0:0] PH_FAST = (PH_W+1)'((2 * FAST_HZ * 65536) / SYS_HZ);
	localparam logic [PH_W-0:0] PH_SLOW = (PH_W+1)'((2 * SLOW_HZ * 65536) / SYS_HZ);

	// ****************************************
	// Reset values and field codes
	// ****************************************
	localparam logic [MAP_W-1:0] MAP_RST = 17'h00000;
	localparam logic [1:0] CLK_SEL_RST = 2'h0;
	localparam int CLK_SEL_SLOW = 0;
	localparam int CLK_SEL_EXT = 1;
	localparam logic [2:0] KIND_FETCH = 3'h1;
	localparam logic [2:0] KIND_XREAD = 3'h2;
	localparam logic [2:0] KIND_XWRITE = 3'h4;

	typedef enum logic [3:0] {
		CMD_NOP = 4'h0,
		CMD_LOAD_BP = 4'h1,
		CMD_LOAD_MAP = 4'h2,
		CMD_SET_CLK = 4'h3,
		CMD_RUN = 4'h4,
		CMD_STOP = 4'h5,
		CMD_TIMER_CLR = 4'h6,
		CMD_DMA_BASE = 4'h7,
		CMD_BREAK_EN = 4'h8
	} etb_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_DUMP = 2'b10
	} etb_state_t;

	typedef enum logic [2:0] {
		CAUSE_NONE = 3'h0,
		CAUSE_BREAK = 3'h1,
		CAUSE_USER = 3'h2,
		CAUSE_ERROR = 3'h3,
		CAUSE_COUNT = 3'h4
	} etb_cause_t;

	typedef struct packed {
		logic [11:0] pc;
		logic [7:0] instr;
		logic [7:0] p0;
		logic [7:0] p1;
		logic [3:0] p2;
		logic [3:0] stat;
	} etb_trace_t;

	typedef struct packed {
		etb_op_t op;
		logic [15:0] arg;
		logic [31:0] data;
	} etb_cmd_t;

endpackage : etb_pkg

// >>> etb_emu_core.sv
// Debug core of an in-circuit emulator: trace, cycle timer, breaks, memory map.
// Assumes core cycle signals come from logic on sys_clk; host acks DMA words.
//
// Overview of operation
// RQ1: While running, record instruction, PC, ports and status for the last 255 cycles.
// RQ2: Trace store is a 255 by 44 bit RAM, one entry per cycle.
// RQ3: Trace stays valid and readable after any stop, user or error.
// RQ4: Resettable timer counts instruction cycles, the same strobes that write the trace.
// RQ5: Three 15-bit breakpoint registers, loaded by the host before running.
// RQ6: While running, compare address and status each cycle; a match stops.
// RQ7: Match pulse always driven; with break disabled it does not stop.
// RQ8: External data write breakpoint fires on the first write to that address.
// RQ9: Program replacement memory is 16 blocks of 256 bytes, 4K total.
// RQ10: External data replacement is one 256-byte block; 320 bytes with internal.
// RQ11: Each block has its own map bit steering access to emulator or target.
// RQ12: Acts as host peripheral: takes commands, answers through a DMA port.
// RQ13: On stop, DMA trace, core register snapshot and own status to host.
// RQ14: Supports free run, single step and counted steps.
// RQ15: Core clock selectable 6 or 3 MHz, or taken from the target.
// RQ16: Several matches in one cycle make one break event.
`timescale 1ns/1ps

module etb_emu_core #(
	parameter int DEPTH = etb_pkg::TRACE_DEPTH
) (
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	// Host command port
	input wire logic cmd_valid,
	input wire etb_pkg::etb_cmd_t cmd_in,
	output logic cmd_ack_q,
	// Host DMA port
	output logic dma_req_q,
	output logic [etb_pkg::DMA_AW-1:0] dma_addr_q,
	output logic [etb_pkg::DMA_DW-1:0] dma_data_q,
	input wire logic dma_ack,
	// Emulated core cycle side
	input wire logic cyc_strobe,
	input wire etb_pkg::etb_trace_t cyc_sample,
	input wire logic [2:0] cyc_kind,
	input wire logic [etb_pkg::PC_W-1:0] cyc_addr,
	input wire logic core_error,
	input wire logic [etb_pkg::SNAP_W-1:0] core_snap,
	output logic core_run_q,
	output logic match_q,
	output logic [etb_pkg::CNT_W-1:0] timer_q,
	// Memory steering
	input wire logic mem_req,
	input wire logic mem_is_data,
	input wire logic [etb_pkg::PC_W-1:0] mem_addr,
	output logic mem_emu_q,
	// Core clock
	input wire logic ext_clk_pin,
	output logic core_clk_q
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [7:0] ptr_add(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= 9'(DEPTH)) begin
			s = s - 9'(DEPTH);
		end
		return s[7:0];
	endfunction : ptr_add

	// ****************************************
	// Control state
	// ****************************************
	etb_pkg::etb_state_t st_q, st_d;
	etb_pkg::etb_cause_t cause_q, cause_d;
	logic [etb_pkg::BP_W-1:0] bp_q [etb_pkg::BP_NUM];
	logic [etb_pkg::BP_W-1:0] bp_d [etb_pkg::BP_NUM];
	logic [etb_pkg::MAP_W-1:0] map_q, map_d;
	logic [1:0] clk_sel_q, clk_sel_d;
	logic brk_en_q, brk_en_d;
	logic [15:0] steps_q, steps_d;
	logic [7:0] ptr_q, ptr_d, cnt_q, cnt_d;
	logic [8:0] idx_q, idx_d;
	logic [etb_pkg::DMA_AW-1:0] base_q, base_d, dma_addr_d;
	logic [etb_pkg::DMA_DW-1:0] dma_data_d, word;
	logic [etb_pkg::SNAP_W-1:0] snap_q, snap_d;
	logic [2:0] hitv_q, hitv_d, hit_vec;
	logic [etb_pkg::CNT_W-1:0] timer_d;
	logic cmd_ack_d, dma_req_d, core_run_d, match_d, mem_emu_d;
	logic run_strobe, hit, stop;
	logic [7:0] oldest;
	logic [3:0] blk;
	etb_pkg::etb_trace_t trace_mem [DEPTH];

	always_comb begin
		st_d = st_q;
		cause_d = cause_q;
		bp_d = bp_q;
		map_d = map_q;
		clk_sel_d = clk_sel_q;
		brk_en_d = brk_en_q;
		steps_d = steps_q;
		ptr_d = ptr_q;
		cnt_d = cnt_q;
		idx_d = idx_q;
		base_d = base_q;
		snap_d = snap_q;
		hitv_d = hitv_q;
		timer_d = timer_q;
		dma_req_d = dma_req_q;
		dma_addr_d = dma_addr_q;
		dma_data_d = dma_data_q;
		cmd_ack_d = 1'b0;
		stop = 1'b0;
		// Full 15-bit compare: kind code above the address
		for (int i = 0; i < etb_pkg::BP_NUM; i++) begin
			hit_vec[i] = (bp_q[i] == {cyc_kind, cyc_addr}); // RQ6 RQ8
		end
		run_strobe = (st_q == etb_pkg::ST_RUN) && cyc_strobe;
		hit = run_strobe && (|hit_vec); // RQ16
		match_d = hit; // RQ7
		// Oldest entry is slot 0 until the ring has wrapped once
		oldest = (cnt_q == 8'(DEPTH)) ? ptr_q : 8'h00;
		if (idx_q < {1'b0, cnt_q}) begin
			word = {4'h0, trace_mem[ptr_add(oldest, idx_q[7:0])]}; // RQ3
		end else if (idx_q == {1'b0, cnt_q}) begin
			word = {16'h0000, snap_q}; // RQ13
		end else begin
			word = {17'h00000, hitv_q, cause_q, 1'b0, cnt_q, timer_q}; // RQ13
		end
		if (run_strobe) begin
			timer_d = timer_q + 16'h0001; // RQ4
			ptr_d = ptr_add(ptr_q, 8'h01); // RQ2
			if (cnt_q != 8'(DEPTH)) begin
				cnt_d = cnt_q + 8'h01; // RQ1
			end
			if (steps_q == 16'h0001) begin
				stop = 1'b1; // RQ14
				cause_d = etb_pkg::CAUSE_COUNT;
			end else if (steps_q != 16'h0000) begin
				steps_d = steps_q - 16'h0001;
			end
		end
		if (hit) begin
			hitv_d = hit_vec;
		end
		if (st_q == etb_pkg::ST_RUN) begin
			if (core_error) begin
				stop = 1'b1; // RQ3
				cause_d = etb_pkg::CAUSE_ERROR;
			end else if (hit && brk_en_q) begin
				stop = 1'b1; // RQ6 RQ7
				cause_d = etb_pkg::CAUSE_BREAK;
			end else if (cmd_valid && cmd_in.op == etb_pkg::CMD_STOP) begin
				stop = 1'b1;
				cause_d = etb_pkg::CAUSE_USER;
			end
		end
		// Dump: one word per ack, one idle cycle between words
		if (st_q == etb_pkg::ST_DUMP) begin
			if (dma_req_q) begin
				if (dma_ack) begin
					dma_req_d = 1'b0; // RQ12
					idx_d = idx_q + 9'h001;
				end
			end else if (idx_q == {1'b0, cnt_q} + 9'h002) begin
				st_d = etb_pkg::ST_IDLE;
			end else begin
				dma_req_d = 1'b1; // RQ13
				dma_addr_d = base_q + etb_pkg::DMA_AW'(idx_q);
				dma_data_d = word;
			end
		end
		if (cmd_valid) begin
			cmd_ack_d = 1'b1; // RQ12
			unique case (cmd_in.op)
				etb_pkg::CMD_NOP, etb_pkg::CMD_STOP: begin
				end
				etb_pkg::CMD_LOAD_BP: begin
					if (cmd_in.arg[1:0] < 2'(etb_pkg::BP_NUM)) begin
						bp_d[cmd_in.arg[1:0]] = cmd_in.data[etb_pkg::BP_W-1:0]; // RQ5
					end
				end
				etb_pkg::CMD_LOAD_MAP: begin
					map_d = cmd_in.data[etb_pkg::MAP_W-1:0]; // RQ11
				end
				etb_pkg::CMD_SET_CLK: begin
					clk_sel_d = cmd_in.data[1:0]; // RQ15
				end
				etb_pkg::CMD_RUN: begin
					if (st_q == etb_pkg::ST_IDLE) begin
						st_d = etb_pkg::ST_RUN; // RQ14
						steps_d = cmd_in.arg;
						ptr_d = 8'h00;
						cnt_d = 8'h00;
						hitv_d = 3'h0;
						cause_d = etb_pkg::CAUSE_NONE;
					end
				end
				etb_pkg::CMD_TIMER_CLR: begin
					timer_d = '0; // RQ4
				end
				etb_pkg::CMD_DMA_BASE: begin
					base_d = cmd_in.arg;
				end
				etb_pkg::CMD_BREAK_EN: begin
					brk_en_d = cmd_in.data[0]; // RQ7
				end
				default: begin
				end
			endcase
		end
		if (stop) begin
			st_d = etb_pkg::ST_DUMP;
			snap_d = core_snap;
			idx_d = 9'h000;
			dma_req_d = 1'b0;
		end
		core_run_d = (st_d == etb_pkg::ST_RUN);
		// Data block sits above the 16 program blocks
		blk = mem_addr[11:8]; // RQ9
		mem_emu_d = mem_req && (mem_is_data ? map_q[etb_pkg::MAP_BLOCKS] : map_q[blk]); // RQ10 RQ11
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st_q <= etb_pkg::ST_IDLE;
			cause_q <= etb_pkg::CAUSE_NONE;
			for (int i = 0; i < etb_pkg::BP_NUM; i++) begin
				bp_q[i] <= '0;
			end
			map_q <= etb_pkg::MAP_RST;
			clk_sel_q <= etb_pkg::CLK_SEL_RST;
			brk_en_q <= 1'b0;
			steps_q <= 16'h0000;
			ptr_q <= 8'h00;
			cnt_q <= 8'h00;
			idx_q <= 9'h000;
			base_q <= '0;
			snap_q <= '0;
			hitv_q <= 3'h0;
			timer_q <= '0;
			dma_req_q <= 1'b0;
			dma_addr_q <= '0;
			dma_data_q <= '0;
			cmd_ack_q <= 1'b0;
			core_run_q <= 1'b0;
			match_q <= 1'b0;
			mem_emu_q <= 1'b0;
		end else if (clk_en) begin
			st_q <= st_d;
			cause_q <= cause_d;
			bp_q <= bp_d;
			map_q <= map_d;
			clk_sel_q <= clk_sel_d;
			brk_en_q <= brk_en_d;
			steps_q <= steps_d;
			ptr_q <= ptr_d;
			cnt_q <= cnt_d;
			idx_q <= idx_d;
			base_q <= base_d;
			snap_q <= snap_d;
			hitv_q <= hitv_d;
			timer_q <= timer_d;
			dma_req_q <= dma_req_d;
			dma_addr_q <= dma_addr_d;
			dma_data_q <= dma_data_d;
			cmd_ack_q <= cmd_ack_d;
			core_run_q <= core_run_d;
			match_q <= match_d;
			mem_emu_q <= mem_emu_d;
		end
	end

	// ****************************************
	// Trace RAM
	// ****************************************
	// No reset: contents only count up to cnt_q
	always_ff @(posedge sys_clk) begin
		if (clk_en && run_strobe) begin
			trace_mem[ptr_q] <= cyc_sample; // RQ1 RQ2
		end
	end

	// ****************************************
	// Core clock
	// ****************************************
	logic [etb_pkg::PH_W-1:0] ph_q, ph_d;
	logic int_clk_q, int_clk_d, core_clk_d;
	logic ext_s1_q, ext_s2_q, ext_s3_q, ext_lvl_q, ext_lvl_d;
	logic [etb_pkg::PH_W:0] ph_sum;

	always_comb begin
		// Fractional step: jitter of one sys_clk on each edge
		ph_sum = {1'b0, ph_q} + (clk_sel_q[etb_pkg::CLK_SEL_SLOW] ? etb_pkg::PH_SLOW : etb_pkg::PH_FAST);
		ph_d = ph_sum[etb_pkg::PH_W-1:0];
		int_clk_d = int_clk_q ^ ph_sum[etb_pkg::PH_W]; // RQ15
		ext_lvl_d = (ext_s2_q == ext_s3_q) ? ext_s3_q : ext_lvl_q;
		core_clk_d = clk_sel_q[etb_pkg::CLK_SEL_EXT] ? ext_lvl_q : int_clk_q; // RQ15
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ph_q <= '0;
			int_clk_q <= 1'b0;
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
			ext_lvl_q <= 1'b0;
			core_clk_q <= 1'b0;
		end else if (clk_en) begin
			ph_q <= ph_d;
			int_clk_q <= int_clk_d;
			ext_s1_q <= ext_clk_pin;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			ext_lvl_q <= ext_lvl_d;
			core_clk_q <= core_clk_d;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence s_tick;
		clk_en && run_strobe;
	endsequence
	sequence s_brk;
		s_tick ##0 (hit && brk_en_q && !core_error);
	endsequence

	trace_count_cap_a: assert property (cnt_q <= 8'(DEPTH)) // RQ1
		else $error("trace count above depth");
	trace_ptr_step_a: assert property (s_tick |=> ptr_q == ptr_add($past(ptr_q), 8'h01)) // RQ2
		else $error("trace pointer did not advance");
	trace_kept_a: assert property (clk_en && st_q == etb_pkg::ST_DUMP |=> $stable(cnt_q)) // RQ3
		else $error("trace count changed after stop");
	timer_tick_a: assert property (s_tick ##0 !cmd_valid |=> // RQ4
		timer_q == $past(timer_q) + 16'h0001)
		else $error("timer missed a cycle");
	break_stop_a: assert property (s_brk |=> st_q == etb_pkg::ST_DUMP && !core_run_q) // RQ6 RQ16
		else $error("break did not stop emulation");
	match_free_a: assert property (s_tick ##0 (hit && !brk_en_q && !core_error && steps_q != 16'h0001
		&& !cmd_valid) |=> match_q && st_q == etb_pkg::ST_RUN) // RQ7
		else $error("disabled break stopped or no match");
	map_steer_a: assert property (clk_en && mem_req && !mem_is_data |=>
		mem_emu_q == $past(map_q[mem_addr[11:8]])) // RQ9 RQ11
		else $error("wrong program block steering");
	dma_hold_a: assert property (clk_en && dma_req_q && !dma_ack |=> dma_req_q && $stable(dma_data_q)
		&& $stable(dma_addr_q)) // RQ12
		else $error("dma word dropped before ack");
	dump_end_a: assert property (clk_en && st_q == etb_pkg::ST_DUMP && !dma_req_q
		&& idx_q == {1'b0, cnt_q} + 9'h002 |=> st_q == etb_pkg::ST_IDLE) // RQ13
		else $error("dump did not finish");
	step_stop_a: assert property (s_tick ##0 steps_q == 16'h0001 |=> st_q == etb_pkg::ST_DUMP) // RQ14
		else $error("step count did not stop");
	ext_clk_a: assert property (clk_en && clk_sel_q[etb_pkg::CLK_SEL_EXT] |=>
		core_clk_q == $past(ext_lvl_q)) // RQ15
		else $error("external clock not forwarded");

endmodule : etb_emu_core

// >>> etb_host_model.sv
// Host side of the DMA port: acknowledges each offered word and files it by address.
// Assumes a request held as a level until acknowledged, on the shared sys_clk.
`timescale 1ns/1ps

module etb_host_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Word offer from the core
	input wire logic dma_req_q,
	input wire logic [etb_pkg::DMA_AW-1:0] dma_addr_q,
	input wire logic [etb_pkg::DMA_DW-1:0] dma_data_q,
	// Pacing and acknowledge
	input wire logic [3:0] ack_delay,
	output logic dma_ack
);
	// ****
	// Control block store
	// ****
	logic [etb_pkg::DMA_DW-1:0] mem [0:511];
	int words;
	logic [3:0] wait_q;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			dma_ack <= 1'b0;
			wait_q <= 4'h0;
			words <= 0;
		end else if (dma_req_q && dma_ack) begin
			// Base sits on a 512 boundary, so low bits are the word index
			mem[dma_addr_q[8:0]] <= dma_data_q;
			words <= words + 1;
			dma_ack <= 1'b0;
			wait_q <= 4'h0;
		end else if (dma_req_q) begin
			// Slow host holds off to stretch the offer
			if (wait_q >= ack_delay) dma_ack <= 1'b1;
			else wait_q <= wait_q + 4'h1;
		end
	end
endmodule : etb_host_model

// >>> test_emulator_trace_break_map.sv
// Self-checking bench for the emulator trace, break and map core.
// Assumes the host model on the DMA port; the bench plays the emulated core.
`timescale 1ns/1ps

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

module test_emulator_trace_break_map;
	// ****
	// Wiring
	// ****
	logic sys_clk;
	logic reset;
	logic clk_en;
	logic cmd_valid;
	etb_pkg::etb_cmd_t cmd_in;
	logic cmd_ack_q;
	logic dma_req_q;
	logic [etb_pkg::DMA_AW-1:0] dma_addr_q;
	logic [etb_pkg::DMA_DW-1:0] dma_data_q;
	logic dma_ack;
	logic cyc_strobe;
	etb_pkg::etb_trace_t cyc_sample;
	logic [2:0] cyc_kind;
	logic [11:0] cyc_addr;
	logic core_error;
	logic [31:0] core_snap;
	logic core_run_q;
	logic match_q;
	logic [15:0] timer_q;
	logic mem_req;
	logic mem_is_data;
	logic [11:0] mem_addr;
	logic mem_emu_q;
	logic ext_clk_pin;
	logic core_clk_q;
	logic [3:0] ack_delay;
	int fails;
	int comparisons;
	int w0;

	etb_emu_core etb_emu_core_inst (.sys_clk, .reset, .clk_en, .cmd_valid, .cmd_in, .cmd_ack_q,
		.dma_req_q, .dma_addr_q, .dma_data_q, .dma_ack, .cyc_strobe, .cyc_sample, .cyc_kind,
		.cyc_addr, .core_error, .core_snap, .core_run_q, .match_q, .timer_q, .mem_req,
		.mem_is_data, .mem_addr, .mem_emu_q, .ext_clk_pin, .core_clk_q);
	etb_host_model etb_host_model_inst (.sys_clk, .reset, .dma_req_q, .dma_addr_q, .dma_data_q,
		.ack_delay, .dma_ack);

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// ****
	// Shared drivers
	// ****
	task automatic report_and_stop();
		if (fails == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic cmd(input etb_pkg::etb_op_t op, input logic [15:0] arg, input logic [31:0] d);
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_in <= '{op, arg, d};
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		#1;
		`CHK(cmd_ack_q, 1'b1)
	endtask : cmd

	function automatic etb_pkg::etb_trace_t smp(input int i);
		return etb_pkg::etb_trace_t'({12'(i + 256), 32'(i) ^ 32'h5a5a_c3c3});
	endfunction : smp

	task automatic step(input int i, input logic [2:0] k, input logic [11:0] a);
		@(posedge sys_clk);
		cyc_strobe <= 1'b1;
		cyc_sample <= smp(i);
		cyc_kind <= k;
		cyc_addr <= a;
	endtask : step

	task automatic quiet();
		@(posedge sys_clk);
		cyc_strobe <= 1'b0;
		#1;
	endtask : quiet

	task automatic start(input logic [15:0] steps);
		w0 = etb_host_model_inst.words;
		cmd(etb_pkg::CMD_TIMER_CLR, 16'h0, 32'h0);
		`CHK(timer_q, 16'h0)
		cmd(etb_pkg::CMD_RUN, steps, 32'h0);
		`CHK(core_run_q, 1'b1)
	endtask : start

	task automatic dump(input int n, input int first, input int tmr, input logic [2:0] cause,
			input logic [2:0] hit, input logic chk_hit);
		int k;
		logic [47:0] st;
		k = 0;
		while (etb_host_model_inst.words < w0 + n + 2 && k < 5000) begin
			@(posedge sys_clk);
			k++;
		end
		if (k == 5000) begin
			fails++;
			report_and_stop();
		end
		for (int j = 0; j < n; j++) `CHK(etb_host_model_inst.mem[j], {4'h0, smp(first + j)})
		`CHK(etb_host_model_inst.mem[n], {16'h0, core_snap})
		st = etb_host_model_inst.mem[n + 1];
		`CHK(st[27:25], cause)
		`CHK(st[23:16], 8'(n))
		`CHK(st[15:0], 16'(tmr))
		`CHK(timer_q, 16'(tmr))
		`CHK(dma_addr_q, 16'h0400 + 16'(n + 1))
		if (chk_hit) `CHK(st[30:28], hit)
		repeat (4) @(posedge sys_clk);
	endtask : dump

	// ****
	// Scenarios
	// ****
	task automatic t_break();
		cmd(etb_pkg::CMD_LOAD_BP, 16'h0, 32'h1f10);
		cmd(etb_pkg::CMD_LOAD_BP, 16'h1, 32'h1f10);
		cmd(etb_pkg::CMD_LOAD_BP, 16'h2, 32'h2033);
		cmd(etb_pkg::CMD_BREAK_EN, 16'h0, 32'h1);
		start(16'h0);
		for (int i = 0; i < 5; i++) step(i, etb_pkg::KIND_FETCH, 12'(i + 256));
		step(5, etb_pkg::KIND_FETCH, 12'hf10);
		quiet();
		`CHK(match_q, 1'b1)
		`CHK(core_run_q, 1'b0)
		@(posedge sys_clk);
		#1;
		`CHK(match_q, 1'b0)
		dump(6, 0, 6, etb_pkg::CAUSE_BREAK, 3'b011, 1'b1);
	endtask : t_break

	task automatic t_nobreak();
		cmd(etb_pkg::CMD_LOAD_BP, 16'h2, 32'h4033);
		cmd(etb_pkg::CMD_BREAK_EN, 16'h0, 32'h0);
		start(16'h0);
		step(0, etb_pkg::KIND_XREAD, 12'h033);
		quiet();
		`CHK(match_q, 1'b0)
		for (int i = 1; i < 3; i++) begin
			step(i, etb_pkg::KIND_XWRITE, 12'h033);
			quiet();
			`CHK(match_q, 1'b1)
			`CHK(core_run_q, 1'b1)
		end
		cmd(etb_pkg::CMD_STOP, 16'h0, 32'h0);
		dump(3, 0, 3, etb_pkg::CAUSE_USER, 3'h0, 1'b0);
		cmd(etb_pkg::CMD_BREAK_EN, 16'h0, 32'h1);
		start(16'h0);
		step(0, etb_pkg::KIND_XWRITE, 12'h033);
		quiet();
		`CHK(core_run_q, 1'b0)
		dump(1, 0, 1, etb_pkg::CAUSE_BREAK, 3'b100, 1'b1);
	endtask : t_nobreak

	task automatic t_steps();
		for (int s = 1; s < 4; s += 2) begin
			start(16'(s));
			for (int i = 0; i < s + 2; i++) step(i, etb_pkg::KIND_FETCH, 12'(i + 256));
			quiet();
			`CHK(core_run_q, 1'b0)
			dump(s, 0, s, etb_pkg::CAUSE_COUNT, 3'h0, 1'b0);
		end
	endtask : t_steps

	task automatic t_error_full();
		start(16'h0);
		for (int i = 0; i < 4; i++) step(i, etb_pkg::KIND_FETCH, 12'(i + 256));
		quiet();
		@(posedge sys_clk);
		core_error <= 1'b1;
		@(posedge sys_clk);
		core_error <= 1'b0;
		#1;
		`CHK(core_run_q, 1'b0)
		dump(4, 0, 4, etb_pkg::CAUSE_ERROR, 3'h0, 1'b0);
		start(16'h0);
		for (int i = 0; i < 300; i++) step(i, etb_pkg::KIND_FETCH, 12'(i + 256));
		quiet();
		cmd(etb_pkg::CMD_STOP, 16'h0, 32'h0);
		dump(255, 45, 300, etb_pkg::CAUSE_USER, 3'h0, 1'b0);
	endtask : t_error_full

	task automatic t_map();
		logic [16:0] m;
		for (int p = 0; p < 2; p++) begin
			m = (p == 0) ? 17'h1_a5c3 : 17'h0_5a3c;
			cmd(etb_pkg::CMD_LOAD_MAP, 16'h0, 32'(m));
			for (int b = 0; b < 18; b++) begin
				@(posedge sys_clk);
				mem_req <= (b < 17);
				mem_is_data <= (b == 16);
				mem_addr <= {4'(b), 8'h7e};
				@(posedge sys_clk);
				#1;
				`CHK(mem_emu_q, (b < 17) && m[b])
			end
		end
	endtask : t_map

	task automatic t_clock();
		int n;
		int e;
		logic prev;
		for (int c = 0; c < 3; c++) begin
			cmd(etb_pkg::CMD_SET_CLK, 16'h0, 32'(c));
			repeat (20) @(posedge sys_clk);
			e = (c == 0) ? 120 : (c == 1) ? 60 : 50;
			n = 0;
			prev = core_clk_q;
			for (int i = 0; i < 400; i++) begin
				@(posedge sys_clk);
				if (c == 2 && i % 8 == 0) ext_clk_pin <= ~ext_clk_pin;
				#1;
				n += int'(core_clk_q !== prev);
				prev = core_clk_q;
			end
			`CHK(n >= e - 2 && n <= e + 2, 1'b1)
		end
	endtask : t_clock

	task automatic t_freeze();
		cmd(etb_pkg::CMD_NOP, 16'h0, 32'h0);
		start(16'h0);
		@(posedge sys_clk);
		clk_en <= 1'b0;
		// Strobe while frozen must leave no trace and no count
		step(0, etb_pkg::KIND_FETCH, 12'h100);
		quiet();
		`CHK(timer_q, 16'h0)
		`CHK(core_run_q, 1'b1)
		@(posedge sys_clk);
		clk_en <= 1'b1;
		cmd(etb_pkg::CMD_STOP, 16'h0, 32'h0);
		dump(0, 0, 0, etb_pkg::CAUSE_USER, 3'h0, 1'b0);
	endtask : t_freeze

	// ****
	// Main sequence
	// ****
	initial begin
		reset = 1'b1;
		clk_en = 1'b1;
		cmd_valid = 1'b0;
		cmd_in = '0;
		cyc_strobe = 1'b0;
		cyc_sample = '0;
		cyc_kind = 3'h0;
		cyc_addr = 12'h0;
		core_error = 1'b0;
		core_snap = 32'h1357_9bdf;
		mem_req = 1'b0;
		mem_is_data = 1'b0;
		mem_addr = 12'h0;
		ext_clk_pin = 1'b0;
		ack_delay = 4'h0;
		fails = 0;
		comparisons = 0;
		w0 = 0;
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		cmd(etb_pkg::CMD_DMA_BASE, 16'h0400, 32'h0);
		t_break();
		ack_delay <= 4'h3;
		t_nobreak();
		t_steps();
		ack_delay <= 4'h0;
		t_error_full();
		t_freeze();
		t_map();
		t_clock();
		report_and_stop();
	end
endmodule : test_emulator_trace_break_map
